// file: shared/pshr_pkg.sv
// constants and carrier types for the pll status and holdover register bank
package pshr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_REF_CFG = 8'h1a;
  localparam logic [7:0] IDX_HOLD_CTRL = 8'h1d;
  localparam logic [7:0] IDX_PLL_STATUS = 8'h1f;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h20;
  localparam logic [7:0] IDX_EVT_MASK = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_REF_CFG = {IDX_REF_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HOLD_CTRL = {IDX_HOLD_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PLL_STATUS = {IDX_PLL_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = {IDX_EVT_MASK, 2'b00};
  // holdover control fields
  localparam int HOLD_EN_LO = 0;
  localparam int EXT_HOLD = 1;
  localparam int HOLD_EN_HI = 2;
  localparam int LD_CMP_EN = 3;
  localparam int STAT_RD_DIS = 4;
  localparam logic [7:0] HOLD_CTRL_WMASK = 8'h1f;
  localparam logic [7:0] HOLD_CTRL_RST = 8'h00;
  // reference config: threshold select only
  localparam int REF_THR_SEL = 6;
  localparam logic [7:0] REF_CFG_WMASK = 8'h40;
  localparam logic [7:0] REF_CFG_RST = 8'h00;
  // pll status fields
  localparam int ST_CAL_DONE = 6;
  localparam int ST_HOLD_ACT = 5;
  localparam int ST_SECOND_REFERENCE_INPUT_SEL = 4;
  localparam int ST_VCO_THR = 3;
  localparam int ST_SECOND_REFERENCE_INPUT_THR = 2;
  localparam int ST_FIRST_REFERENCE_INPUT_THR = 1;
  localparam int ST_LOCKED = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // event status / mask fields
  localparam int EVT_W = 3;
  localparam int EVT_CAL_DONE = 0;
  localparam int EVT_HOLD_ENTER = 1;
  localparam int EVT_LOCK_LOST = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pshr_apb_req_t;

  typedef struct packed {
    logic vco_cal_done;
    logic holdover_active;
    logic second_ref_sel;
    logic vco_above_thr;
    logic second_reference_input_above_thr;
    logic first_reference_input_above_thr;
    logic pll_locked;
  } pshr_pll_stat_t;

  // unused top bit is forced to zero
  function automatic logic [7:0] pshr_pack_status(input pshr_pll_stat_t s);
    logic [7:0] w;
    w = 8'h00;
    w[ST_CAL_DONE] = s.vco_cal_done;
    w[ST_HOLD_ACT] = s.holdover_active;
    w[ST_SECOND_REFERENCE_INPUT_SEL] = s.second_ref_sel;
    w[ST_VCO_THR] = s.vco_above_thr;
    w[ST_SECOND_REFERENCE_INPUT_THR] = s.second_reference_input_above_thr;
    w[ST_FIRST_REFERENCE_INPUT_THR] = s.first_reference_input_above_thr;
    w[ST_LOCKED] = s.pll_locked;
    return w;
  endfunction : pshr_pack_status
endpackage : pshr_pkg

// file: verilog/pshr_regs.sv
// apb register bank for pll status and holdover control
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - holdover is enabled only when both holdover enable bits 0 and 2 are set
// - holdover enable bits reset to 0; writing 1 to both enables holdover
// - status bit 6 is 1 once vco calibration finished, else 0
// - status bit 5 is 1 while actually in holdover, separate from enable
// - status bit 4 is 1 when second reference feeds the pll, else 0
// - status bit 3 is 1 when vco frequency is above threshold
// - status bit 2 is 1 when second reference exceeds threshold chosen by 0x1a bit 6
// - status bit 1 is 1 when first reference exceeds the selected threshold
// - status bit 0 follows digital lock detect
// - status readback disable bit 4 of holdover control hides status; default enabled
module pshr_regs (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire pshr_pkg::pshr_apb_req_t apb_in,
  output logic pready_out,
  output logic [pshr_pkg::DATA_W-1:0] prdata_out,
  output logic pslverr_out,
  input wire pshr_pkg::pshr_pll_stat_t pll_stat_in,
  output logic holdover_enable_out,
  output logic ext_holdover_out,
  output logic ld_cmp_enable_out,
  output logic threshold_sel_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] hold_ctrl_q, hold_ctrl_d;
  logic [7:0] ref_cfg_q, ref_cfg_d;
  logic [7:0] status_q, status_d;
  logic [7:0] prev_status_q, prev_status_d;
  logic [pshr_pkg::EVT_W-1:0] evt_q, evt_d;
  logic [pshr_pkg::EVT_W-1:0] mask_q, mask_d;
  logic [pshr_pkg::EVT_W-1:0] rd_evt_q, rd_evt_d;
  logic [pshr_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic hold_en_q, hold_en_d;
  logic irq_q, irq_d;

  logic setup_c;
  logic wr_c;
  logic rd_done_c;
  logic [pshr_pkg::EVT_W-1:0] new_evt_c;

  function automatic logic pshr_mapped(input logic [pshr_pkg::ADDR_W-1:0] a);
    return (a == pshr_pkg::ADDR_REF_CFG) || (a == pshr_pkg::ADDR_HOLD_CTRL) ||
           (a == pshr_pkg::ADDR_PLL_STATUS) || (a == pshr_pkg::ADDR_EVT_STATUS) ||
           (a == pshr_pkg::ADDR_EVT_MASK);
  endfunction : pshr_mapped

  // zero wait states: every access phase completes at once
  assign pready_out = 1'b1;
  assign setup_c = apb_in.psel && !apb_in.penable;
  assign wr_c = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd_done_c = apb_in.psel && apb_in.penable && !apb_in.pwrite &&
                     (apb_in.paddr == pshr_pkg::ADDR_EVT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    hold_ctrl_d = hold_ctrl_q;
    ref_cfg_d = ref_cfg_q;
    mask_d = mask_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    rd_evt_d = rd_evt_q;
    // status is resampled every cycle, so writes never land there
    status_d = pshr_pkg::pshr_pack_status(pll_stat_in);
    prev_status_d = status_q;
    new_evt_c = '0;
    new_evt_c[pshr_pkg::EVT_CAL_DONE] = status_q[pshr_pkg::ST_CAL_DONE] &&
                                        !prev_status_q[pshr_pkg::ST_CAL_DONE];
    new_evt_c[pshr_pkg::EVT_HOLD_ENTER] = status_q[pshr_pkg::ST_HOLD_ACT] &&
                                          !prev_status_q[pshr_pkg::ST_HOLD_ACT];
    new_evt_c[pshr_pkg::EVT_LOCK_LOST] = !status_q[pshr_pkg::ST_LOCKED] &&
                                         prev_status_q[pshr_pkg::ST_LOCKED];
    if (wr_c) begin
      case (apb_in.paddr)
        pshr_pkg::ADDR_HOLD_CTRL: begin
          hold_ctrl_d = apb_in.pwdata[7:0] & pshr_pkg::HOLD_CTRL_WMASK;
        end
        pshr_pkg::ADDR_REF_CFG: begin
          ref_cfg_d = apb_in.pwdata[7:0] & pshr_pkg::REF_CFG_WMASK;
        end
        pshr_pkg::ADDR_EVT_MASK: begin
          mask_d = apb_in.pwdata[pshr_pkg::EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // read data is captured in the setup cycle and held through access
    if (setup_c) begin
      prdata_d = '0;
      pslverr_d = !pshr_mapped(apb_in.paddr);
      rd_evt_d = '0;
      case (apb_in.paddr)
        pshr_pkg::ADDR_HOLD_CTRL: prdata_d[7:0] = hold_ctrl_q;
        pshr_pkg::ADDR_REF_CFG: prdata_d[7:0] = ref_cfg_q;
        pshr_pkg::ADDR_PLL_STATUS: begin
          if (!hold_ctrl_q[pshr_pkg::STAT_RD_DIS]) begin
            prdata_d[7:0] = status_q;
          end
        end
        pshr_pkg::ADDR_EVT_STATUS: begin
          prdata_d[pshr_pkg::EVT_W-1:0] = evt_q;
          rd_evt_d = evt_q;
        end
        pshr_pkg::ADDR_EVT_MASK: prdata_d[pshr_pkg::EVT_W-1:0] = mask_q;
        default: prdata_d = '0;
      endcase
    end
    // only bits already returned are cleared, and a fresh event wins
    evt_d = (rd_done_c ? (evt_q & ~rd_evt_q) : evt_q) | new_evt_c;
    hold_en_d = hold_ctrl_d[pshr_pkg::HOLD_EN_LO] && hold_ctrl_d[pshr_pkg::HOLD_EN_HI];
    irq_d = |(evt_d & mask_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hold_ctrl_q <= pshr_pkg::HOLD_CTRL_RST;
      ref_cfg_q <= pshr_pkg::REF_CFG_RST;
      status_q <= pshr_pkg::STATUS_RST;
      prev_status_q <= pshr_pkg::STATUS_RST;
      evt_q <= pshr_pkg::EVT_RST;
      mask_q <= pshr_pkg::MASK_RST;
      rd_evt_q <= pshr_pkg::EVT_RST;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      hold_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      hold_ctrl_q <= hold_ctrl_d;
      ref_cfg_q <= ref_cfg_d;
      status_q <= status_d;
      prev_status_q <= prev_status_d;
      evt_q <= evt_d;
      mask_q <= mask_d;
      rd_evt_q <= rd_evt_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      hold_en_q <= hold_en_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q;
  assign holdover_enable_out = hold_en_q;
  assign ext_holdover_out = hold_ctrl_q[pshr_pkg::EXT_HOLD];
  assign ld_cmp_enable_out = hold_ctrl_q[pshr_pkg::LD_CMP_EN];
  assign threshold_sel_out = ref_cfg_q[pshr_pkg::REF_THR_SEL];
  assign irq_out = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_hold_both_set: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_HOLD_CTRL && apb_in.pwdata[0] && apb_in.pwdata[2]
    |=> holdover_enable_out)
    else $error("holdover not enabled with both bits set");

  a_hold_one_clear: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_HOLD_CTRL && !(apb_in.pwdata[0] && apb_in.pwdata[2])
    |=> !holdover_enable_out)
    else $error("holdover enabled without both bits");

  a_hold_reset_off: assert property (disable iff (1'b0)
    !rst_n_in |=> !holdover_enable_out && hold_ctrl_q == pshr_pkg::HOLD_CTRL_RST)
    else $error("holdover enable not cleared by reset");

  // the edge that leaves reset still loads zeros, so it is skipped
  a_cal_bit_track: assert property (
    $past(rst_n_in) |-> status_q[pshr_pkg::ST_CAL_DONE] == $past(pll_stat_in.vco_cal_done))
    else $error("cal finished bit wrong");

  a_hold_act_track: assert property (
    $past(rst_n_in) |-> status_q[pshr_pkg::ST_HOLD_ACT] == $past(pll_stat_in.holdover_active))
    else $error("holdover active bit wrong");

  a_ref_sel_track: assert property (
    $past(rst_n_in) |-> status_q[pshr_pkg::ST_SECOND_REFERENCE_INPUT_SEL] == $past(pll_stat_in.second_ref_sel))
    else $error("reference select bit wrong");

  a_freq_bits: assert property (
    $past(rst_n_in) |-> status_q[3:1] == {$past(pll_stat_in.vco_above_thr),
                          $past(pll_stat_in.second_reference_input_above_thr), $past(pll_stat_in.first_reference_input_above_thr)})
    else $error("frequency threshold bits wrong");

  a_lock_read: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_PLL_STATUS && !hold_ctrl_q[pshr_pkg::STAT_RD_DIS]
    |=> prdata_out[pshr_pkg::ST_LOCKED] == $past(status_q[pshr_pkg::ST_LOCKED]))
    else $error("lock bit not read back");

  a_status_hidden: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_PLL_STATUS && hold_ctrl_q[pshr_pkg::STAT_RD_DIS]
    |=> prdata_out == '0)
    else $error("status visible while readback disabled");

  a_status_top_zero: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_PLL_STATUS |=> prdata_out[31:7] == '0)
    else $error("unused status bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // bus and register checks

  a_ctrl_write_lands: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_HOLD_CTRL
    |=> hold_ctrl_q == $past(apb_in.pwdata[7:0] & pshr_pkg::HOLD_CTRL_WMASK))
    else $error("holdover control write lost");

  a_ctrl_kept: assert property (
    !(wr_c && apb_in.paddr == pshr_pkg::ADDR_HOLD_CTRL)
    |=> hold_ctrl_q == $past(hold_ctrl_q))
    else $error("holdover control changed without a write");

  a_ctrl_top_zero: assert property (
    hold_ctrl_q[7:5] == 3'h0)
    else $error("holdover control spare bits set");

  a_ref_write_lands: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_REF_CFG
    |=> ref_cfg_q == $past(apb_in.pwdata[7:0] & pshr_pkg::REF_CFG_WMASK))
    else $error("reference config write lost");

  a_ref_kept: assert property (
    !(wr_c && apb_in.paddr == pshr_pkg::ADDR_REF_CFG)
    |=> ref_cfg_q == $past(ref_cfg_q))
    else $error("reference config changed without a write");

  a_ref_top_zero: assert property (
    (ref_cfg_q & ~pshr_pkg::REF_CFG_WMASK) == 8'h00)
    else $error("reference config spare bits set");

  a_thr_sel_drive: assert property (
    threshold_sel_out == ref_cfg_q[pshr_pkg::REF_THR_SEL])
    else $error("threshold select output wrong");

  a_hold_en_level: assert property (
    holdover_enable_out == (hold_ctrl_q[pshr_pkg::HOLD_EN_LO] && hold_ctrl_q[pshr_pkg::HOLD_EN_HI]))
    else $error("holdover enable differs from its two bits");

  a_ext_hold_drive: assert property (
    ext_holdover_out == hold_ctrl_q[pshr_pkg::EXT_HOLD])
    else $error("external holdover output wrong");

  a_ld_cmp_drive: assert property (
    ld_cmp_enable_out == hold_ctrl_q[pshr_pkg::LD_CMP_EN])
    else $error("comparator enable output wrong");

  a_ctrl_read_back: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_HOLD_CTRL
    |=> prdata_out[7:0] == $past(hold_ctrl_q))
    else $error("holdover control read wrong");

  a_status_wr_ignored: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_PLL_STATUS
    |=> status_q == $past(pshr_pkg::pshr_pack_status(pll_stat_in)))
    else $error("status register took a write");

  a_status_top_reg: assert property (
    status_q[7] == 1'b0)
    else $error("status spare bit set");

  a_status_read_match: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_PLL_STATUS && !hold_ctrl_q[pshr_pkg::STAT_RD_DIS]
    |=> prdata_out[6:0] == $past(status_q[6:0]))
    else $error("status read data wrong");

  // read data must not move in the cycle after the access phase
  a_prdata_stands: assert property (
    setup_c ##1 (apb_in.psel && apb_in.penable)
    |=> $stable(prdata_out))
    else $error("read data moved during access");

  a_err_unmapped: assert property (
    setup_c && !pshr_mapped(apb_in.paddr)
    |=> pslverr_out)
    else $error("no error for unmapped address");

  a_err_mapped: assert property (
    setup_c && pshr_mapped(apb_in.paddr)
    |=> !pslverr_out)
    else $error("error for mapped address");

  a_unmapped_zero: assert property (
    setup_c && !pshr_mapped(apb_in.paddr)
    |=> prdata_out == '0)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // event checks

  a_prev_follows: assert property (
    ##1 prev_status_q == $past(status_q))
    else $error("status history wrong");

  a_cal_evt_set: assert property (
    status_q[pshr_pkg::ST_CAL_DONE] && !prev_status_q[pshr_pkg::ST_CAL_DONE]
    |=> evt_q[pshr_pkg::EVT_CAL_DONE])
    else $error("cal finished event lost");

  a_hold_evt_set: assert property (
    status_q[pshr_pkg::ST_HOLD_ACT] && !prev_status_q[pshr_pkg::ST_HOLD_ACT]
    |=> evt_q[pshr_pkg::EVT_HOLD_ENTER])
    else $error("holdover entry event lost");

  a_lock_evt_set: assert property (
    !status_q[pshr_pkg::ST_LOCKED] && prev_status_q[pshr_pkg::ST_LOCKED]
    |=> evt_q[pshr_pkg::EVT_LOCK_LOST])
    else $error("lock lost event missing");

  a_evt_read_clear: assert property (
    rd_done_c && rd_evt_q[pshr_pkg::EVT_LOCK_LOST] && !new_evt_c[pshr_pkg::EVT_LOCK_LOST]
    |=> !evt_q[pshr_pkg::EVT_LOCK_LOST])
    else $error("event not cleared by read");

  a_evt_no_spurious: assert property (
    (evt_q == '0) && !(|new_evt_c)
    |=> evt_q == '0)
    else $error("event set with no cause");

  a_irq_level: assert property (
    irq_out == |(evt_q & mask_q))
    else $error("interrupt level wrong");

  a_mask_write_lands: assert property (
    wr_c && apb_in.paddr == pshr_pkg::ADDR_EVT_MASK
    |=> mask_q == $past(apb_in.pwdata[pshr_pkg::EVT_W-1:0]))
    else $error("mask write lost");

  a_evt_read_data: assert property (
    setup_c && apb_in.paddr == pshr_pkg::ADDR_EVT_STATUS
    |=> prdata_out[pshr_pkg::EVT_W-1:0] == $past(evt_q))
    else $error("event status read wrong");

endmodule : pshr_regs

// file: verif/pshr_regs_bench.sv
// self-checking bench for the pll status and holdover register bank
`timescale 1ns/100ps
module pshr_regs_bench;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  pshr_pkg::pshr_apb_req_t apb_in = '0;
  pshr_pkg::pshr_pll_stat_t pll_stat_in = '0;
  logic pready_out;
  logic [31:0] prdata_out;
  logic pslverr_out;
  logic holdover_enable_out;
  logic threshold_sel_out;
  logic ext_hold_out;
  logic ld_cmp_out;
  logic irq_out;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checks = 0;

  always #4 clock_in = ~clock_in;

  pshr_regs i_pshr_regs (.clock_in(clock_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .pll_stat_in(pll_stat_in), .holdover_enable_out(holdover_enable_out),
    .ext_holdover_out(ext_hold_out), .ld_cmp_enable_out(ld_cmp_out),
    .threshold_sel_out(threshold_sel_out),
    .irq_out(irq_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; only the watchdog ends a wait on a dead slave
  task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] wdata);
    @(posedge clock_in);
    apb_in.psel <= 1'b1;
    apb_in.penable <= 1'b0;
    apb_in.pwrite <= wr;
    apb_in.paddr <= addr;
    apb_in.pwdata <= wdata;
    @(posedge clock_in);
    apb_in.penable <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1) begin
      @(posedge clock_in);
    end
    rd = prdata_out;
    err = pslverr_out;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [9:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cycles

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(pshr_pkg::ADDR_HOLD_CTRL, 32'h0);
    check(32'(holdover_enable_out), 32'h0);
    $display("reset test done");
  endtask : t_reset

  // both enable bits are needed; one alone must leave holdover off
  task automatic t_hold_en();
    logic [7:0] vals [4];
    vals = '{8'h01, 8'h04, 8'h05, 8'h00};
    // calibration is marked finished first; holdover enable does not depend on it
    pll_stat_in.vco_cal_done <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pshr_pkg::ADDR_HOLD_CTRL, {24'h0, vals[i]});
      cycles(2);
      check(32'(holdover_enable_out), 32'(vals[i][0] & vals[i][2]));
      rd_chk(pshr_pkg::ADDR_HOLD_CTRL, {24'h0, vals[i]});
    end
    apb(1'b1, pshr_pkg::ADDR_HOLD_CTRL, 32'h0a);
    cycles(2);
    check(32'(ext_hold_out), 32'h1);
    check(32'(ld_cmp_out), 32'h1);
    check(32'(holdover_enable_out), 32'h0);
    apb(1'b1, pshr_pkg::ADDR_REF_CFG, 32'h40);
    cycles(2);
    check(32'(threshold_sel_out), 32'h1);
    $display("holdover enable test done");
  endtask : t_hold_en

  // walking one over the status inputs, then write attempt and readback disable
  task automatic t_status();
    for (int i = 0; i < 7; i++) begin
      pll_stat_in <= pshr_pkg::pshr_pll_stat_t'(7'h01 << i);
      cycles(2);
      rd_chk(pshr_pkg::ADDR_PLL_STATUS, 32'h1 << i);
    end
    pll_stat_in <= '1;
    cycles(2);
    apb(1'b1, pshr_pkg::ADDR_PLL_STATUS, 32'h0);
    rd_chk(pshr_pkg::ADDR_PLL_STATUS, 32'h7f);
    apb(1'b1, pshr_pkg::ADDR_HOLD_CTRL, 32'h10);
    rd_chk(pshr_pkg::ADDR_PLL_STATUS, 32'h0);
    apb(1'b1, pshr_pkg::ADDR_HOLD_CTRL, 32'h0);
    rd_chk(pshr_pkg::ADDR_PLL_STATUS, 32'h7f);
    apb(1'b0, 10'h3fc, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    $display("status test done");
  endtask : t_status

  task automatic lock_blip();
    pll_stat_in.pll_locked <= 1'b1;
    cycles(4);
    pll_stat_in.pll_locked <= 1'b0;
    cycles(4);
  endtask : lock_blip

  // lost lock raises irq when unmasked; the read clears it
  task automatic t_irq();
    pll_stat_in <= '0;
    apb(1'b1, pshr_pkg::ADDR_EVT_MASK, 32'h7);
    cycles(4);
    apb(1'b0, pshr_pkg::ADDR_EVT_STATUS, 32'h0);
    cycles(2);
    check(32'(irq_out), 32'h0);
    lock_blip();
    check(32'(irq_out), 32'h1);
    rd_chk(pshr_pkg::ADDR_EVT_STATUS, 32'h4);
    cycles(2);
    check(32'(irq_out), 32'h0);
    apb(1'b1, pshr_pkg::ADDR_EVT_MASK, 32'h0);
    lock_blip();
    check(32'(irq_out), 32'h0);
    rd_chk(pshr_pkg::ADDR_EVT_STATUS, 32'h4);
    $display("interrupt test done");
  endtask : t_irq

  // reset in mid run with holdover on must drop every holdover control bit
  task automatic t_reset_run();
    pll_stat_in.vco_cal_done <= 1'b1;
    apb(1'b1, pshr_pkg::ADDR_HOLD_CTRL, 32'h0f);
    cycles(2);
    check(32'(holdover_enable_out), 32'h1);
    rst_n_in <= 1'b0;
    cycles(3);
    rst_n_in <= 1'b1;
    check(32'(holdover_enable_out), 32'h0);
    check(32'(ext_hold_out), 32'h0);
    check(32'(ld_cmp_out), 32'h0);
    rd_chk(pshr_pkg::ADDR_HOLD_CTRL, 32'h0);
    $display("mid run reset test done");
  endtask : t_reset_run

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_hold_en();
    t_status();
    t_irq();
    t_reset_run();
    stop_test();
  end
endmodule : pshr_regs_bench
